// file: verilog/oad_pkg.sv
/*
  Package for the operand-addressing decode block: flag layout, opcodes,
  addressing modes, bus-cycle counts and the request/answer structs.
  Assumes one 125 MHz clock and a byte-wide memory bus with one-cycle reads.
*/
package oad_pkg;

  // ==========================================================================
  // flag register layout
  localparam int FLAG_OVF_BIT  = 7;
  localparam int FLAG_HALF_BIT = 4;
  localparam int FLAG_IMSK_BIT = 3;
  localparam int FLAG_NEG_BIT  = 2;
  localparam int FLAG_ZERO_BIT = 1;
  localparam int FLAG_CARY_BIT = 0;
  localparam logic [7:0]  FLAG_RESET  = 8'h08;
  localparam logic [15:0] SP_RESET    = 16'h00FF;
  localparam logic [15:0] HX_RESET    = 16'h0000;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] ADDR_STEP   = 16'h0001;
  localparam logic [7:0]  DIRECT_HIGH = 8'h00;

  // ==========================================================================
  // opcodes handled here
  localparam logic [7:0] OP_STACK_PREFIX   = 8'h9E;
  localparam logic [7:0] OP_BRANCH_CC      = 8'h24;
  localparam logic [7:0] OP_STACK_ADJ      = 8'hA7;
  localparam logic [7:0] OP_INDEX_ADJ      = 8'hAF;
  localparam logic [7:0] OP_ADC_IMM        = 8'hA9;
  localparam logic [7:0] OP_ADD_IMM        = 8'hAB;
  localparam logic [7:0] OP_COMPARE_BRANCH_EQUAL_IX1P      = 8'h61;
  localparam logic [7:0] OP_COMPARE_BRANCH_EQUAL_IXP       = 8'h71;
  localparam logic [7:0] OP_MOV_IXP_DIR    = 8'h7E;
  localparam logic [7:0] OP_LDHX_IMM       = 8'h45;
  localparam logic [7:0] OP_BSET0_DIR      = 8'h10;
  localparam logic [3:0] ADD_LOW_NIB       = 4'hB;
  localparam logic [3:0] ADC_LOW_NIB       = 4'h9;
  localparam logic [3:0] HI_IMM            = 4'hA;
  localparam logic [3:0] HI_DIR            = 4'hB;
  localparam logic [3:0] HI_EXT            = 4'hC;
  localparam logic [3:0] HI_IX2            = 4'hD;
  localparam logic [3:0] HI_IX1            = 4'hE;
  localparam logic [3:0] HI_IX             = 4'hF;
  localparam logic [3:0] HI_BITOPS         = 4'h1;

  // bus cycles of the conditional branch on carry clear
  localparam int BRANCH_CYCLES = 3;

  // ==========================================================================
  // addressing modes
  typedef enum logic [11:0] {
    no_operand_mode         = 12'h001,
    literal_operand_mode    = 12'h002,
    direct_mode             = 12'h004,
    long_address_mode       = 12'h008,
    index_mode              = 12'h010,
    index_off8_mode         = 12'h020,
    index_off16_mode        = 12'h040,
    index_postinc_mode      = 12'h080,
    index_off8_postinc_mode = 12'h100,
    stack_off8_mode         = 12'h200,
    stack_off16_mode        = 12'h400,
    relative_mode           = 12'h800
  } oad_mode_type;

  // sequencer states
  typedef enum logic [6:0] {
    ST_FETCH  = 7'h01,
    ST_OPND1  = 7'h02,
    ST_OPND2  = 7'h04,
    ST_ADDR   = 7'h08,
    ST_DATA   = 7'h10,
    ST_IDLE   = 7'h20,
    ST_FAULT  = 7'h40
  } oad_state_type;

  // memory request and answer
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } oad_mem_req_type;

  typedef struct packed {
    logic [7:0] data;
  } oad_mem_rsp_type;

  // visible core state
  typedef struct packed {
    logic [7:0]  flag_register;
    logic [7:0]  acc;
    logic [15:0] index_pair;
    logic [15:0] stack_pointer;
    logic [15:0] prog_counter;
  } oad_core_type;

endpackage

// file: verilog/oad_decode.sv
/*
  Operand-addressing and early-opcode decode for an 8-bit CPU on a 16-bit
  address bus. Fetches opcode and operand bytes, forms effective addresses,
  runs the adjust, branch, add and post-increment instructions it knows.
  Assumes memory answers each address within its cycle; the byte is taken at the next edge.
*/
`timescale 1ns/100ps

// ============================================================================
// Summary of operation
// RULE_01 - flags: V7 H4 I3 N2 Z1 C0
// RULE_02 - carry is carry out of bit seven
// RULE_03 - 16-bit memory values are big-endian
// RULE_04 - direct page: high address byte zero
// RULE_05 - branch target relative to next instruction
// RULE_06 - 16-bit index offset adds modulo 65536
// RULE_07 - 8-bit index offsets zero-extended
// RULE_08 - off8 mode: index pair plus byte
// RULE_09 - off16 mode: index pair plus word
// RULE_10 - stack modes: stack pointer plus offset
// RULE_11 - post-increment modes only for listed instructions
// RULE_12 - two-byte offset fetched high byte first
// RULE_13 - extended address fetched high byte first
// RULE_14 - 16-bit immediate fetched high byte first
// RULE_15 - bit number field selects bits 0-7
// RULE_16 - stack/index adjust sign-extends, flags untouched
// RULE_17 - opcode 24 branches on carry clear
// RULE_18 - off8 post-increment bumps index after fetch
// RULE_19 - add and add-with-carry update five flags
// RULE_20 - prefix 9E selects stack-relative form
module oad_decode
  import oad_pkg::*;
(
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  // memory bus
  output oad_mem_req_type      mem_req,
  input  wire oad_mem_rsp_type mem_rsp,
  // state and status
  output oad_core_type         core,
  output oad_mode_type         cur_mode,
  output logic [15:0]          eff_addr,
  output logic [2:0]           bit_select,
  output logic                 bad_opcode,
  output logic                 instr_done
);

  // ==========================================================================
  // registers
  oad_state_type state;
  oad_state_type next_state;
  logic [7:0]    opcode;
  logic          prefixed;
  logic [7:0]    opnd_hi;
  logic [7:0]    opnd_lo;
  logic [1:0]    opnd_len;
  logic [7:0]    flags;
  logic [7:0]    acc;
  logic [15:0]   hx;
  logic [15:0]   sp;
  logic [15:0]   pc;
  logic [15:0]   ea;
  logic [1:0]    bus_count;
  logic [7:0]    rd_data;

  // ==========================================================================
  // decode of the byte just fetched as opcode
  oad_mode_type dec_mode;
  logic [1:0]   dec_len;
  logic         dec_ok;
  logic [3:0]   op_hi;

  assign rd_data = mem_rsp.data;
  assign op_hi   = rd_data[7:4];

  always_comb begin
    dec_mode = no_operand_mode;
    dec_len  = 2'd0;
    dec_ok   = 1'b1;
    if (prefixed) begin
      // [RULE_20] stack forms reuse the index-form opcode after the prefix
      if (op_hi == HI_IX2 && (rd_data[3:0] == ADD_LOW_NIB || rd_data[3:0] == ADC_LOW_NIB)) begin
        dec_mode = stack_off16_mode;  // [RULE_10]
        dec_len  = 2'd2;
      end else if (op_hi == HI_IX1 && (rd_data[3:0] == ADD_LOW_NIB || rd_data[3:0] == ADC_LOW_NIB)) begin
        dec_mode = stack_off8_mode;   // [RULE_10]
        dec_len  = 2'd1;
      end else begin
        dec_ok = 1'b0;
      end
    end else begin
      case (rd_data)
        OP_BRANCH_CC: begin
          dec_mode = relative_mode;
          dec_len  = 2'd1;
        end
        OP_STACK_ADJ, OP_INDEX_ADJ, OP_ADC_IMM, OP_ADD_IMM: begin
          dec_mode = literal_operand_mode;
          dec_len  = 2'd1;
        end
        OP_LDHX_IMM: begin
          dec_mode = literal_operand_mode;
          dec_len  = 2'd2;
        end
        // [RULE_11] post-increment forms exist only for these opcodes
        OP_COMPARE_BRANCH_EQUAL_IX1P: begin
          dec_mode = index_off8_postinc_mode;
          dec_len  = 2'd2;
        end
        OP_COMPARE_BRANCH_EQUAL_IXP: begin
          dec_mode = index_postinc_mode;
          dec_len  = 2'd1;
        end
        OP_MOV_IXP_DIR: begin
          dec_mode = index_postinc_mode;
          dec_len  = 2'd1;
        end
        OP_STACK_PREFIX: begin
          dec_mode = no_operand_mode;
          dec_len  = 2'd0;
        end
        default: begin
          if (op_hi == HI_BITOPS) begin
            dec_mode = direct_mode;
            dec_len  = 2'd1;
          end else if (rd_data[3:0] == ADD_LOW_NIB || rd_data[3:0] == ADC_LOW_NIB) begin
            case (op_hi)
              HI_DIR: begin
                dec_mode = direct_mode;
                dec_len  = 2'd1;
              end
              HI_EXT: begin
                dec_mode = long_address_mode;
                dec_len  = 2'd2;
              end
              HI_IX2: begin
                dec_mode = index_off16_mode;
                dec_len  = 2'd2;
              end
              HI_IX1: begin
                dec_mode = index_off8_mode;
                dec_len  = 2'd1;
              end
              HI_IX: begin
                dec_mode = index_mode;
                dec_len  = 2'd0;
              end
              default: dec_ok = 1'b0;
            endcase
          end else begin
            dec_ok = 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // effective address from the collected operand bytes
  logic [15:0] opnd_word;
  logic [15:0] next_ea;

  // [RULE_03] [RULE_12] [RULE_13] [RULE_14] first byte fetched is the high byte
  assign opnd_word = (opnd_len == 2'd2) ? {opnd_hi, opnd_lo} : {8'h00, opnd_hi};

  always_comb begin
    next_ea = 16'h0000;
    case (cur_mode)
      direct_mode:             next_ea = {DIRECT_HIGH, opnd_hi};         // [RULE_04]
      long_address_mode:       next_ea = opnd_word;                      // [RULE_13]
      index_mode:              next_ea = hx;
      index_postinc_mode:      next_ea = hx;
      index_off8_mode:         next_ea = hx + {8'h00, opnd_hi};          // [RULE_07] [RULE_08]
      index_off8_postinc_mode: next_ea = hx + {8'h00, opnd_hi};          // [RULE_07]
      index_off16_mode:        next_ea = hx + opnd_word;                 // [RULE_06] [RULE_09]
      stack_off8_mode:         next_ea = sp + {8'h00, opnd_hi};          // [RULE_10]
      stack_off16_mode:        next_ea = sp + opnd_word;                 // [RULE_10]
      relative_mode:           next_ea = pc + {{8{opnd_hi[7]}}, opnd_hi}; // [RULE_05]
      default:                 next_ea = 16'h0000;
    endcase
  end

  // ==========================================================================
  // sequencer; one byte read every cycle while running
  logic       needs_data;

  assign needs_data = (cur_mode != no_operand_mode) && (cur_mode != literal_operand_mode)
                      && (cur_mode != relative_mode);

  always_comb begin
    next_state = state;
    case (state)
      ST_FETCH: begin
        if (!dec_ok)
          next_state = ST_FAULT;
        else if (!prefixed && rd_data == OP_STACK_PREFIX)
          next_state = ST_FETCH;
        else if (dec_len != 2'd0)
          next_state = ST_OPND1;
        else
          next_state = ST_ADDR;
      end
      ST_OPND1: next_state = (opnd_len == 2'd2) ? ST_OPND2 : ST_ADDR;
      ST_OPND2: next_state = ST_ADDR;
      // a branch skips the idle cycle to keep its three bus cycles
      ST_ADDR:  next_state = (cur_mode == relative_mode) ? ST_FETCH
                             : (needs_data ? ST_DATA : ST_IDLE);  // [RULE_17]
      ST_DATA:  next_state = ST_IDLE;
      ST_IDLE:  next_state = (bus_count == 2'd0) ? ST_FETCH : ST_IDLE;
      ST_FAULT: next_state = ST_FAULT;
      default:  next_state = ST_FAULT;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      state <= ST_FETCH;
    else
      state <= next_state;
  end

  // pending read for the first cycle after reset is the opcode at pc
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      opcode   <= 8'h00;
      prefixed <= 1'b0;
      opnd_len <= 2'd0;
      cur_mode <= no_operand_mode;
      opnd_hi  <= 8'h00;
      opnd_lo  <= 8'h00;
    end else begin
      case (state)
        ST_FETCH: begin
          opcode   <= rd_data;
          prefixed <= !prefixed && rd_data == OP_STACK_PREFIX;
          opnd_len <= dec_len;
          cur_mode <= dec_mode;
        end
        ST_OPND1: begin
          opnd_hi <= rd_data;  // [RULE_12]
        end
        ST_OPND2: begin
          opnd_lo <= rd_data;  // [RULE_12]
        end
        default: ;
      endcase
    end
  end

  // branch takes fixed bus cycles; only the branch loads bus_count, and idle waits while it is nonzero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      bus_count <= 2'd0;
    else if (state == ST_FETCH && !prefixed && rd_data == OP_BRANCH_CC)
      bus_count <= 2'(BRANCH_CYCLES - 3);  // [RULE_17]
    else if (state == ST_IDLE && bus_count != 2'd0)
      bus_count <= bus_count - 2'd1;
  end

  // ==========================================================================
  // memory address: program counter while fetching, ea for data
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      pc <= PC_RESET;
    // pc still holds the offset byte address, so the target lies one further
    else if (state == ST_ADDR && cur_mode == relative_mode && !flags[FLAG_CARY_BIT])
      pc <= next_ea + ADDR_STEP;  // [RULE_17] [RULE_05]
    else if (next_state == ST_FETCH || next_state == ST_OPND1 || next_state == ST_OPND2)
      pc <= pc + ADDR_STEP;
  end

  always_comb begin
    mem_req.rd   = (state != ST_FAULT);
    mem_req.addr = (state == ST_DATA) ? ea : pc;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      ea <= 16'h0000;
    else if (state == ST_ADDR)
      ea <= next_ea;
  end

  // ==========================================================================
  // execution: adjusts, adds, post-increment
  logic [8:0] sum;
  logic [4:0] half;
  logic       use_carry;
  logic [7:0] operand;
  logic       do_add;

  assign operand   = (state == ST_DATA) ? rd_data : opnd_hi;
  assign use_carry = (opcode[3:0] == ADC_LOW_NIB) && flags[FLAG_CARY_BIT];
  assign sum       = {1'b0, acc} + {1'b0, operand} + {8'h00, use_carry};
  assign half      = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, use_carry};
  assign do_add    = (opcode[3:0] == ADD_LOW_NIB || opcode[3:0] == ADC_LOW_NIB)
                     && ((state == ST_ADDR && cur_mode == literal_operand_mode)
                     || (state == ST_DATA && opcode[7:4] >= HI_DIR));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc   <= 8'h00;
      flags <= FLAG_RESET;
    end else if (do_add) begin
      // [RULE_19] interrupt mask kept
      acc                  <= sum[7:0];
      flags[FLAG_CARY_BIT] <= sum[8];  // [RULE_02] [RULE_01]
      flags[FLAG_HALF_BIT] <= half[4];
      flags[FLAG_NEG_BIT]  <= sum[7];
      flags[FLAG_ZERO_BIT] <= (sum[7:0] == 8'h00);
      flags[FLAG_OVF_BIT]  <= (acc[7] == operand[7]) && (sum[7] != acc[7]);
    end
  end

  logic [15:0] imm_sx;
  assign imm_sx = {{8{opnd_hi[7]}}, opnd_hi};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      sp <= SP_RESET;
    else if (state == ST_ADDR && opcode == OP_STACK_ADJ && !prefixed)
      sp <= sp + imm_sx;  // [RULE_16]
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      hx <= HX_RESET;
    else if (state == ST_ADDR && opcode == OP_INDEX_ADJ)
      hx <= hx + imm_sx;  // [RULE_16]
    else if (state == ST_ADDR && opcode == OP_LDHX_IMM)
      hx <= opnd_word;    // [RULE_14]
    else if (state == ST_DATA && (cur_mode == index_postinc_mode
             || cur_mode == index_off8_postinc_mode))
      hx <= hx + ADDR_STEP;  // [RULE_18] [RULE_11]
  end

  // ==========================================================================
  // outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      instr_done <= 1'b0;
      bad_opcode <= 1'b0;
      bit_select <= 3'd0;
    end else begin
      instr_done <= (state == ST_IDLE && bus_count == 2'd0)
                    || (state == ST_ADDR && cur_mode == relative_mode);
      bad_opcode <= (next_state == ST_FAULT);
      if (state == ST_FETCH && op_hi == HI_BITOPS)
        bit_select <= rd_data[3:1];  // [RULE_15]
    end
  end

  assign eff_addr           = ea;
  assign core.flag_register = flags;
  assign core.acc           = acc;
  assign core.index_pair    = hx;
  assign core.stack_pointer = sp;
  assign core.prog_counter  = pc;

endmodule

// file: verification/oad_decode_props.sv
/*
  Checker for the operand-addressing decode block, bound to its ports.
  Assumes the single clock ref_clk and the asynchronous active-low nrst.
*/
`timescale 1ns/100ps

module oad_decode_props
  import oad_pkg::*;
(
  // clock and reset
  input wire logic            ref_clk,
  input wire logic            nrst,
  // memory bus
  input wire oad_mem_req_type mem_req,
  input wire oad_mem_rsp_type mem_rsp,
  // state and status
  input wire oad_core_type    core,
  input wire oad_mode_type    cur_mode,
  input wire logic [15:0]     eff_addr,
  input wire logic [2:0]      bit_select,
  input wire logic            bad_opcode,
  input wire logic            instr_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ==========
  // sequencing and refusal
  a_done_spacing: assert property ((instr_done && cur_mode != relative_mode)
    |-> !$past(instr_done) && !$past(instr_done, 2) && !$past(instr_done, 3))
    else $error("instruction ends closer than four cycles apart");
  a_branch_cycles: assert property ((instr_done && cur_mode == relative_mode)
    |-> $past(instr_done, 3))
    else $error("carry-clear branch did not take three cycles");
  a_fault_sticky: assert property (bad_opcode |=> bad_opcode)
    else $error("fault flag dropped without reset");
  a_fault_no_read: assert property (bad_opcode |=> !mem_req.rd)
    else $error("reads continue after an unknown opcode");

  // ==========
  // flags and addresses
  a_mask_stable: assert property ($stable(core.flag_register[FLAG_IMSK_BIT]))
    else $error("interrupt mask changed");
  a_direct_high: assert property ((cur_mode == direct_mode && $changed(eff_addr))
    |-> eff_addr[15:8] == DIRECT_HIGH)
    else $error("direct address left the first page");
  a_off8_zero_ext: assert property ((cur_mode == index_off8_mode && $changed(eff_addr))
    |-> (eff_addr - core.index_pair) <= 16'h00FF)
    else $error("index offset not zero-extended");
  a_stack_zero_ext: assert property ((cur_mode == stack_off8_mode && $changed(eff_addr))
    |-> (eff_addr - core.stack_pointer) <= 16'h00FF)
    else $error("stack offset not zero-extended");
  a_postinc_step: assert property (((cur_mode == index_postinc_mode
    || cur_mode == index_off8_postinc_mode) && $changed(core.index_pair))
    |-> core.index_pair == $past(core.index_pair) + ADDR_STEP)
    else $error("post-increment step is not one");

  c_index_done: cover property (instr_done && cur_mode == index_off8_mode);
  c_postinc: cover property (instr_done && cur_mode == index_off8_postinc_mode);
  c_branch: cover property (instr_done && cur_mode == relative_mode);
  c_fault: cover property ($rose(bad_opcode));
endmodule

bind oad_decode oad_decode_props u_props (
  .ref_clk(ref_clk), .nrst(nrst), .mem_req(mem_req), .mem_rsp(mem_rsp),
  .core(core), .cur_mode(cur_mode), .eff_addr(eff_addr), .bit_select(bit_select),
  .bad_opcode(bad_opcode), .instr_done(instr_done)
);

// file: verification/oad_mem_model.sv
/*
  Byte-wide program and data memory facing the decode block.
  Assumes a request every cycle; answers with that byte within the same cycle.
*/
`timescale 1ns/100ps

module oad_mem_model
  import oad_pkg::*;
(
  // clock
  input  wire logic            ref_clk,
  // memory bus
  input  wire oad_mem_req_type mem_req,
  output oad_mem_rsp_type      mem_rsp
);
  logic [7:0]  bytes [65536];
  logic [7:0]  spin = 8'h00;

  // preset so that data reads never return unknowns
  initial begin
    for (int a = 0; a < 65536; a++)
      bytes[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5A;
  end

  always @(posedge ref_clk) begin
    spin <= spin + 8'h3B;
  end

  // asynchronous read: the block takes the byte at the edge ending the request
  // a released bus shows a moving pattern, never the last byte
  assign mem_rsp.data = mem_req.rd ? bytes[mem_req.addr] : spin;
endmodule

// file: verification/oad_decode_tb.sv
/*
  Self-checking bench for the decode block: corner cases, then random
  instructions, an unknown opcode and a second reset. Memory is a model.
*/
`timescale 1ns/100ps

module oad_decode_tb
  import oad_pkg::*;
;
  logic            ref_clk = 1'b0;
  logic            nrst;
  oad_mem_req_type mem_req;
  oad_mem_rsp_type mem_rsp;
  oad_core_type    core;
  oad_mode_type    cur_mode;
  logic [15:0]     eff_addr;
  logic [2:0]      bit_select;
  logic            bad_opcode;
  logic            instr_done;
  int              num_errors;
  int              n_compared;
  logic [15:0]     exp_pc;
  logic [15:0]     exp_hx;
  logic [15:0]     exp_sp;
  logic [7:0]      exp_acc;
  logic [7:0]      exp_flags;
  // kind, first operand, second operand
  logic [19:0]     corners [19] = '{'h0FFF0, 'h8F000, 'h18000, 'h27F00, 'h3FF00, 'h30100,
    'h40000, 'hB8000, 'h3FF00, 'hB7F00, 'h7FFFF, 'hCFF00, 'hD0000, 'hE0000, 'h9FF00,
    'hAFFFF, 'hF0701, 'h5FF00, 'h61234};

  always #4 ref_clk = ~ref_clk;

  oad_decode dut (.ref_clk(ref_clk), .nrst(nrst), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .core(core), .cur_mode(cur_mode), .eff_addr(eff_addr), .bit_select(bit_select),
    .bad_opcode(bad_opcode), .instr_done(instr_done));
  oad_mem_model mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rsp(mem_rsp));

  // ==========
  // checking helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [15:0] sx(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  // new flags and accumulator of an add; the mask bit rides through
  function automatic logic [15:0] add_res(input logic [7:0] a, input logic [7:0] m,
                                          input logic [7:0] f, input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, m} + 9'(cin);
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + 5'(cin);
    f[FLAG_OVF_BIT]  = (a[7] == m[7]) && (s[7] != a[7]);
    f[FLAG_HALF_BIT] = h[4];
    f[FLAG_NEG_BIT]  = s[7];
    f[FLAG_ZERO_BIT] = (s[7:0] == 8'h00);
    f[FLAG_CARY_BIT] = s[8];
    return {f, s[7:0]};
  endfunction

  // ==========
  // one instruction: place it, predict, run, compare
  task automatic do_op(input int kind, input logic [7:0] x, input logic [7:0] y);
    logic [7:0]  op;
    logic [2:0]  n;
    logic [2:0]  eak;
    logic [1:0]  hxk;
    logic [15:0] ea;
    logic [15:0] jump;
    logic [31:0] code;
    int          i;
    case (kind)
      0: {op, n, eak, hxk} = {8'h45, 3'd3, 3'd0, 2'd1};
      1: {op, n, eak, hxk} = {8'hAF, 3'd2, 3'd0, 2'd2};
      2: {op, n, eak, hxk} = {8'hA7, 3'd2, 3'd0, 2'd0};
      3: {op, n, eak, hxk} = {8'hAB, 3'd2, 3'd0, 2'd0};
      4: {op, n, eak, hxk} = {8'hA9, 3'd2, 3'd0, 2'd0};
      5: {op, n, eak, hxk} = {8'hBB, 3'd2, 3'd1, 2'd0};
      6: {op, n, eak, hxk} = {8'hCB, 3'd3, 3'd2, 2'd0};
      7: {op, n, eak, hxk} = {8'hDB, 3'd3, 3'd3, 2'd0};
      8: {op, n, eak, hxk} = {8'hEB, 3'd2, 3'd4, 2'd0};
      9: {op, n, eak, hxk} = {8'hEB, 3'd3, 3'd5, 2'd0};
      10: {op, n, eak, hxk} = {8'hDB, 3'd4, 3'd6, 2'd0};
      11: {op, n, eak, hxk} = {8'h24, 3'd2, 3'd0, 2'd0};
      12: {op, n, eak, hxk} = {8'h61, 3'd3, 3'd4, 2'd3};
      13: {op, n, eak, hxk} = {8'h71, 3'd2, 3'd7, 2'd3};
      14: {op, n, eak, hxk} = {8'h7E, 3'd2, 3'd0, 2'd3};
      default: {op, n, eak, hxk} = {4'h1, x[2:0], y[0], 3'd2, 3'd1, 2'd0};
    endcase
    code = (kind == 9 || kind == 10) ? {8'h9E, op, x, y} : {op, x, y, 8'h00};
    for (i = 0; i < n; i++)
      mem.bytes[16'(exp_pc + i)] = code[31 - 8 * i -: 8];
    case (eak)
      1: ea = {8'h00, x};
      2: ea = {x, y};
      3: ea = exp_hx + {x, y};
      4: ea = exp_hx + {8'h00, x};
      5: ea = exp_sp + {8'h00, x};
      6: ea = exp_sp + {x, y};
      default: ea = exp_hx;
    endcase
    if (kind >= 3 && kind <= 10)
      {exp_flags, exp_acc} = add_res(exp_acc, (kind < 5) ? x : mem.bytes[ea], exp_flags,
                                     kind == 4 && exp_flags[FLAG_CARY_BIT]);
    jump = (kind == 11 && !exp_flags[FLAG_CARY_BIT]) ? sx(x) : 16'h0000;
    case (hxk)
      1: exp_hx = {x, y};
      2: exp_hx = exp_hx + sx(x);
      3: exp_hx = exp_hx + ADDR_STEP;
      default: ;
    endcase
    if (kind == 2)
      exp_sp = exp_sp + sx(x);
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      #1;
      if (instr_done === 1'b1)
        break;
    end
    exp_pc = exp_pc + 16'(n) + jump;
    chk(16'(instr_done), 16'h0001, "done");
    if (kind == 11)
      chk(16'(i), 16'(BRANCH_CYCLES - 1), "branch cycles");
    chk(core.prog_counter, exp_pc, "pc");
    chk(16'(core.acc), 16'(exp_acc), "acc");
    chk(16'(core.flag_register), 16'(exp_flags), "flags");
    chk(core.index_pair, exp_hx, "index");
    chk(core.stack_pointer, exp_sp, "stack");
    if (eak != 3'd0)
      chk(eff_addr, ea, "address");
    if (kind == 15)
      chk(16'(bit_select), 16'(x[2:0]), "bit");
  endtask

  // ==========
  // main sequence
  initial begin
    nrst = 1'b0;
    num_errors = 0;
    n_compared = 0;
    exp_pc = PC_RESET;
    exp_hx = HX_RESET;
    exp_sp = SP_RESET;
    exp_acc = 8'h00;
    exp_flags = FLAG_RESET;
    void'($urandom(32'hBB16AB97));
    repeat (2) @(posedge ref_clk);
    #1;
    chk(16'(core.flag_register), 16'(FLAG_RESET), "reset flags");
    nrst = 1'b1;
    foreach (corners[k])
      do_op(int'(corners[k][19:16]), corners[k][15:8], corners[k][7:0]);
    $display("corner cases done");
    repeat (300)
      do_op(int'($urandom_range(15, 0)), 8'($urandom), 8'($urandom));
    $display("random instructions done");
    mem.bytes[exp_pc] = 8'h80;
    for (int w = 0; w < 12 && bad_opcode !== 1'b1; w++)
      @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    chk(16'(bad_opcode), 16'h0001, "fault flag");
    chk(16'(mem_req.rd), 16'h0000, "fault read");
    $display("unknown opcode done");
    nrst = 1'b0;
    #2;
    chk(core.prog_counter, PC_RESET, "second reset");
    chk(16'(bad_opcode), 16'h0000, "fault cleared");
    $display("second reset done");
    exp_pc = PC_RESET;
    exp_hx = HX_RESET;
    exp_sp = SP_RESET;
    exp_acc = 8'h00;
    exp_flags = FLAG_RESET;
    repeat (2) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    do_op(3, 8'h80, 8'h00);
    do_op(11, 8'h05, 8'h00);
    $display("restart done");
    test_done();
  end

  // generous against about 1600 cycles of tests
  initial begin
    #(8 * 20000);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule
